// >>> rtl/err_status_pkg.sv
// package: error status word layout, offsets and reset values
package err_status_pkg;
  localparam int STATUS_W = 14;
  localparam int BIT_WEAK_FIELD = 12;
  localparam int BIT_STRONG_FIELD = 11;
  localparam int BIT_BIAS_RANGE = 10;
  localparam int BIT_ANGLE_OVF = 9;
  localparam int BIT_CONV_OVF = 8;
  localparam int BIT_MEAS_BUSY = 4;
  localparam int BIT_BAD_ADDR = 2;
  localparam int BIT_CLK_COUNT = 1;
  localparam int BIT_PARITY = 0;
  localparam logic [13:0] ERROR_STATUS_OFFSET = 14'h335A;
  localparam logic [13:0] ERROR_STATUS_RESET = 14'h0000;
  localparam logic [13:0] ERROR_STATUS_USED_MASK = 14'h1F17;
  localparam int GAIN_W = 6;
  localparam logic [5:0] GAIN_MIN_DEFAULT = 6'h00;
  localparam logic [5:0] GAIN_MAX_DEFAULT = 6'h3F;
endpackage : err_status_pkg

// >>> rtl/sensor_error_status_monitor.sv
// error status word capture for a magnetic angle sensor
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bit 9 is set when the angle calculation inputs are too large for a valid result.
// - Bit 8 is set when field strength exceeds converter range on any Hall element.
// - Bit 8 may also be raised while the power-up offset loop has not yet converged.
// - Bit 4 reads 1 while a position-read command is being processed.
// - Bit 4 returns to 0 when the started measurement completes.
// - Bit 2 is set when a serial access uses an address not in the map.
// - Bit 1 is set when a frame carries the wrong number of clock cycles.
// - Bit 0 is set when the received parity differs from the computed parity.
// - Bit 12 is set at gain level at or above maximum, bit 11 at or below minimum.
// - Bit 10 is set when the Hall bias circuit reaches its headroom limit.
// - A communication fault keeps the error flag set until the error-clear or chip-reset command.
module sensor_error_status_monitor
  import err_status_pkg::*;
#(
  parameter logic [5:0] GAIN_MIN = GAIN_MIN_DEFAULT,
  parameter logic [5:0] GAIN_MAX = GAIN_MAX_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic angle_calc_overflow_in,
  input wire logic hall_overrange_in,
  input wire logic offset_loop_settled_in,
  input wire logic meas_start_in,
  input wire logic meas_done_in,
  input wire logic bias_headroom_in,
  input wire logic [5:0] gain_control_level_in,
  input wire logic frame_end_in,
  input wire logic frame_addr_valid_in,
  input wire logic frame_clk_count_ok_in,
  input wire logic frame_parity_ok_in,
  input wire logic error_clear_in,
  input wire logic chip_reset_in,
  output logic [13:0] error_status_out,
  output logic comm_error_flag_out
);
  logic angle_calc_overflow;
  logic converter_overflow;
  logic measurement_in_progress;
  logic bad_address_flag;
  logic clock_count_flag;
  logic parity_flag;
  logic weak_field_alarm;
  logic strong_field_alarm;
  logic bias_range;
  logic comm_clear;
  logic [13:0] next_status;

  assign comm_clear = error_clear_in | chip_reset_in;

  // dsp side flags follow live conditions
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      angle_calc_overflow <= 1'b0;
      converter_overflow <= 1'b0;
      weak_field_alarm <= 1'b0;
      strong_field_alarm <= 1'b0;
      bias_range <= 1'b0;
    end else begin
      angle_calc_overflow <= angle_calc_overflow_in;
      converter_overflow <= hall_overrange_in | ~offset_loop_settled_in;
      weak_field_alarm <= (gain_control_level_in >= GAIN_MAX);
      strong_field_alarm <= (gain_control_level_in <= GAIN_MIN);
      bias_range <= bias_headroom_in;
    end
  end

  // measurement busy flag
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || chip_reset_in) begin
      measurement_in_progress <= 1'b0;
    end else if (meas_start_in) begin
      measurement_in_progress <= 1'b1;
    end else if (meas_done_in) begin
      measurement_in_progress <= 1'b0;
    end
  end

  // serial fault flags, sticky until error clear or chip reset
  sticky_flag u_bad_addr (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .set_in(frame_end_in & ~frame_addr_valid_in),
    .clear_in(comm_clear),
    .flag_out(bad_address_flag)
  );
  sticky_flag u_clk_count (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .set_in(frame_end_in & ~frame_clk_count_ok_in),
    .clear_in(comm_clear),
    .flag_out(clock_count_flag)
  );
  sticky_flag u_parity (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .set_in(frame_end_in & ~frame_parity_ok_in),
    .clear_in(comm_clear),
    .flag_out(parity_flag)
  );

  // status word assembly, reserved bits zero
  always_comb begin
    next_status = ERROR_STATUS_RESET;
    next_status[BIT_WEAK_FIELD] = weak_field_alarm;
    next_status[BIT_STRONG_FIELD] = strong_field_alarm;
    next_status[BIT_BIAS_RANGE] = bias_range;
    next_status[BIT_ANGLE_OVF] = angle_calc_overflow;
    next_status[BIT_CONV_OVF] = converter_overflow;
    next_status[BIT_MEAS_BUSY] = measurement_in_progress;
    next_status[BIT_BAD_ADDR] = bad_address_flag;
    next_status[BIT_CLK_COUNT] = clock_count_flag;
    next_status[BIT_PARITY] = parity_flag;
    next_status = next_status & ERROR_STATUS_USED_MASK;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      error_status_out <= ERROR_STATUS_RESET;
      comm_error_flag_out <= 1'b0;
    end else begin
      error_status_out <= next_status;
      comm_error_flag_out <= bad_address_flag | clock_count_flag | parity_flag;
    end
  end
endmodule : sensor_error_status_monitor
`default_nettype wire

// >>> rtl/sticky_flag.sv
// sticky flag: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule : sticky_flag
`default_nettype wire

// >>> testbench/sensor_error_status_monitor_asserts.sv
// error status checker
`timescale 1ns/1ps
`default_nettype none
module sensor_error_status_monitor_asserts import err_status_pkg::*; (
  input wire logic sys_clk_in, srst_in, angle_calc_overflow_in, hall_overrange_in,
  input wire logic offset_loop_settled_in, meas_start_in, meas_done_in, frame_end_in,
  input wire logic frame_parity_ok_in, error_clear_in, comm_error_flag_out, chip_reset_in,
  input wire logic frame_addr_valid_in, frame_clk_count_ok_in,
  input wire logic [13:0] error_status_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_angle_live: assert property (error_status_out[9] == $past(angle_calc_overflow_in, 2))
    else $error("b9");
  a_conv_live: assert property (error_status_out[8] ==
    $past(hall_overrange_in | !offset_loop_settled_in, 2)) else $error("b8");
  a_busy_set: assert property (meas_start_in && !chip_reset_in |-> ##2 error_status_out[4])
    else $error("b4");
  a_addr_set: assert property (frame_end_in && !frame_addr_valid_in |->
    ##2 error_status_out[2]) else $error("b2");
  a_clk_set: assert property (frame_end_in && !frame_clk_count_ok_in |->
    ##2 error_status_out[1]) else $error("b1");
  a_busy_clr: assert property (meas_done_in && !meas_start_in |-> ##2 !error_status_out[4])
    else $error("b4");
  a_parity_set: assert property (frame_end_in && !frame_parity_ok_in |->
    ##2 error_status_out[0]) else $error("b0");
  a_err_clear: assert property (error_clear_in && !frame_end_in |->
    ##2 error_status_out[2:0] == 3'h0) else $error("clr");
  a_comm_or: assert property (comm_error_flag_out == |error_status_out[2:0])
    else $error("ef");
  a_rsvd_zero: assert property ((error_status_out & ~ERROR_STATUS_USED_MASK) == 14'h0000)
    else $error("rsvd");
  c_parity: cover property (frame_end_in && !frame_parity_ok_in);
  c_busy: cover property (meas_start_in);
  c_clear: cover property (error_clear_in && error_status_out[0]);
endmodule : sensor_error_status_monitor_asserts
`default_nettype wire

// >>> testbench/sensor_error_status_monitor_bench.sv
// random bench for the status monitor
`timescale 1ns/1ps
`default_nettype none
module sensor_error_status_monitor_bench;
  logic clk = 1'h0, rst = 1'h1, fe, ef;
  logic [2:0] ok;
  logic [13:0] w, e1 = 14'h0000, e0 = 14'h0000;
  logic [17:0] d = 18'h00008;
  logic [15:0] r = 16'h10ED;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  spi_host_model u_host (.clk_in(clk), .go_in(d[8]), .fault_in(d[11:9]), .frame_end_out(fe),
    .ok_out(ok));
  sensor_error_status_monitor u_dut (.sys_clk_in(clk), .srst_in(rst),
    .angle_calc_overflow_in(d[0]), .hall_overrange_in(d[1]), .bias_headroom_in(d[2]),
    .offset_loop_settled_in(d[3]), .meas_start_in(d[4]), .meas_done_in(d[5]),
    .error_clear_in(d[6]), .chip_reset_in(d[7]), .gain_control_level_in(d[17:12]),
    .frame_end_in(fe), .frame_addr_valid_in(ok[2]), .frame_clk_count_ok_in(ok[1]),
    .frame_parity_ok_in(ok[0]), .error_status_out(w), .comm_error_flag_out(ef));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [13:0] next_word(input logic [13:0] v);
    return {1'h0, d[17:12] == 6'h3F, d[17:12] == 6'h00, d[2], d[0], d[1] | ~d[3], 3'h0,
      ~d[7] & (d[4] | v[4] & ~d[5]), 1'h0, (fe ? ~ok : 3'h0) | v[2:0] & {3{~d[6] & ~d[7]}}};
  endfunction : next_word
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) if (++cyc > 900) begin
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    for (int i = 0; i < 600; i++) begin
      @(negedge clk);
      n_checks++;
      if (w !== e0) begin
        err_total++;
        $display("mismatch %0t got %h exp %h", $time, w, e0);
      end
      n_checks++;
      if (ef !== |e0[2:0]) begin
        err_total++;
        $display("mismatch %0t comm flag got %b", $time, ef);
      end
      e0 = e1;
      e1 = next_word(e1);
      @(posedge clk);
      #1 r = lfsr(r);
      d = {r[15:7], i % 100 < 70 ? {r[6], 1'h0, r[5] & r[4], r[4] & r[3], r[5] & r[3]} :
        {1'h0, i % 100 == 99, 3'h0}, r[3] | i > 30, r[2:0]};
    end
    print_verdict();
  end
endmodule : sensor_error_status_monitor_bench
bind sensor_error_status_monitor sensor_error_status_monitor_asserts u_chk (.*);
`default_nettype wire

// >>> testbench/spi_host_model.sv
// host frame model
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [2:0] fault_in,
  output logic frame_end_out,
  output logic [2:0] ok_out
);
  always @(posedge clk_in) begin
    frame_end_out <= go_in;
    ok_out <= go_in ? ~fault_in : ~ok_out;
  end
endmodule : spi_host_model
`default_nettype wire
